// file: design/mbpt_pkg.sv
// Constants and types for the serial master port translator
package mbpt_pkg;
  // Clock and reply-interval time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned REPLY_UNIT_US = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * REPLY_UNIT_US;
  localparam int unsigned TICK_W = 17;

  // Coil translation
  localparam logic [15:0] COILS_PER_REG = 16'h0010;
  localparam logic [15:0] FIRST_COIL = 16'h0001;
  localparam logic [15:0] ONE_REG = 16'h0001;
  localparam logic [15:0] COIL_ON = 16'hff00;
  localparam logic [15:0] COIL_OFF = 16'h0000;

  // Retry limit: transmissions per request
  localparam logic [1:0] MAX_TX = 2'h3;

  // Function codes on the serial line
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_REGS = 8'h03;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_COILS = 8'h0f;
  localparam logic [7:0] FC_WR_REGS = 8'h10;

  // Request queue
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned REQ_W = 47;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    MBPT_OP_RD_REGS = 3'b000,
    MBPT_OP_WR_REGS = 3'b001,
    MBPT_OP_RD_COILS = 3'b010,
    MBPT_OP_WR_COILS = 3'b011,
    MBPT_OP_WR_ONE_COIL = 3'b100
  } mbpt_op_e;

  typedef enum logic [1:0] {
    MBPT_POINT_TO_POINT_DRIVER = 2'b00,
    MBPT_DRIVER_MODE_A = 2'b01,
    MBPT_DRIVER_MODE_B = 2'b10
  } mbpt_drv_e;

  typedef enum logic [1:0] {
    MBPT_ST_IDLE = 2'b00,
    MBPT_ST_SEND = 2'b01,
    MBPT_ST_WAIT = 2'b10
  } mbpt_state_e;
endpackage

// file: design/mbpt_port.sv
// Request queue and serial master port translator with driver control
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Coil start = ((register index + offset - 1) * 16) + 1 for bit requests.
// - Coil translation applies only to function codes 1, 5 and 15.
// - Each register maps to sixteen coils starting on a sixteen-coil boundary.
// - First coil is register bit zero; later bits map to following coils.
// - After sending, wait up to the programmed reply interval for a valid reply.
// - On no valid reply, resend the identical request and wait again.
// - At most two resends, so at most three transmissions per request.
// - Point-to-point mode keeps the driver on and allows full duplex.
// - Mode A drives the line while CTS is asserted, floats it otherwise.
// - Mode B drives as mode A and disables the receiver while transmitting.

module mbpt_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + {AW'(0), push} - {AW'(0), pop});
    end
  end

  // Storage carries no reset; only the pointers define what is valid
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk) begin
      if (push && (wr_q == AW'(i))) begin
        mem_q[i] <= in_data;
      end
    end
  end
endmodule

module mbpt_port #(
  parameter int unsigned TICK = mbpt_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Upstream request
  input wire logic req_valid,
  output logic req_ready,
  input wire mbpt_pkg::mbpt_op_e req_op,
  input wire logic [7:0] req_slave,
  input wire logic [15:0] req_index,
  input wire logic [3:0] req_bit_sel,
  input wire logic [15:0] req_data,
  // Upstream completion
  output logic done_valid,
  output logic done_fail,
  output logic [15:0] done_data,
  // Configuration
  input wire logic [15:0] addr_offset,
  input wire logic [15:0] reply_timeout_ms,
  input wire mbpt_pkg::mbpt_drv_e driver_mode,
  // Frame to serializer
  output logic frm_valid,
  input wire logic frm_ready,
  output logic [7:0] frm_slave,
  output logic [7:0] frm_func,
  output logic [15:0] frm_addr,
  output logic [15:0] frm_qty,
  output logic [15:0] frm_data,
  // Reply from deserializer
  input wire logic rpl_valid,
  input wire logic rpl_ok,
  input wire logic [15:0] rpl_data,
  input wire logic tx_busy,
  // Line transceiver
  input wire logic cts,
  output logic tx_drv_oe,
  output logic rx_enable,
  // Status
  output logic [1:0] tx_count
);
  import mbpt_pkg::*;

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK - 1);

  typedef struct packed {
    mbpt_state_e st;
    logic [1:0] tries;
    logic [TICK_W-1:0] tick;
    logic [15:0] ms_left;
    logic frm_valid;
    logic [7:0] slave;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] data;
    logic [3:0] bit_sel;
    logic done_valid;
    logic done_fail;
    logic [15:0] done_data;
    logic cts_m;
    logic cts_s;
    logic tx_oe;
    logic rx_en;
  } mbpt_port_s;

  mbpt_port_s s_q;
  mbpt_port_s s_d;

  logic q_valid;
  logic q_ready;
  logic [REQ_W-1:0] q_data;
  logic [2:0] q_op_bits;
  mbpt_op_e q_op;
  logic [7:0] q_slave;
  logic [15:0] q_index;
  logic [3:0] q_bit_sel;
  logic [15:0] q_wdata;
  logic [15:0] reg_base;
  logic [15:0] coil_base;
  logic reply_good;
  logic timeout_now;

  // Queue absorbs bursts from upstream while a slave is slow to answer
  mbpt_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data({req_op, req_slave, req_index, req_bit_sel, req_data}),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // Enum field is recovered by an explicit cast, not through the bit unpacking
  assign {q_op_bits, q_slave, q_index, q_bit_sel, q_wdata} = q_data;
  assign q_op = mbpt_op_e'(q_op_bits);
  assign q_ready = (s_q.st == MBPT_ST_IDLE);

  // Wraps at 16 bits like the serial address field
  assign reg_base = 16'(q_index + addr_offset);
  assign coil_base = 16'(16'(reg_base - ONE_REG) * COILS_PER_REG + FIRST_COIL);

  assign reply_good = rpl_valid && rpl_ok;
  assign timeout_now = (s_q.st == MBPT_ST_WAIT) && !reply_good && (s_q.tick == TICK_LAST)
                       && (s_q.ms_left <= 16'h0001);

  always_comb begin
    s_d = s_q;
    s_d.done_valid = 1'b0;
    s_d.cts_m = cts;
    s_d.cts_s = s_q.cts_m;
    case (driver_mode)
      MBPT_POINT_TO_POINT_DRIVER: begin
        s_d.tx_oe = 1'b1;
        s_d.rx_en = 1'b1;
      end
      MBPT_DRIVER_MODE_A: begin
        s_d.tx_oe = s_q.cts_s;
        s_d.rx_en = 1'b1;
      end
      MBPT_DRIVER_MODE_B: begin
        s_d.tx_oe = s_q.cts_s;
        s_d.rx_en = !(tx_busy || s_q.frm_valid);
      end
      default: begin
        s_d.tx_oe = 1'b0;
        s_d.rx_en = 1'b1;
      end
    endcase
    case (s_q.st)
      MBPT_ST_IDLE: begin
        if (q_valid) begin
          s_d.slave = q_slave;
          s_d.bit_sel = q_bit_sel;
          s_d.tries = 2'h0;
          s_d.frm_valid = 1'b1;
          s_d.st = MBPT_ST_SEND;
          case (q_op)
            MBPT_OP_RD_COILS: begin
              s_d.func = FC_RD_COILS;
              s_d.addr = coil_base;
              s_d.qty = COILS_PER_REG;
              s_d.data = RST_WORD;
            end
            MBPT_OP_WR_COILS: begin
              // Register bit 0 goes to the first coil of the group
              s_d.func = FC_WR_COILS;
              s_d.addr = coil_base;
              s_d.qty = COILS_PER_REG;
              s_d.data = q_wdata;
            end
            MBPT_OP_WR_ONE_COIL: begin
              s_d.func = FC_WR_COIL;
              s_d.addr = 16'(coil_base + {12'h000, q_bit_sel});
              s_d.qty = ONE_REG;
              s_d.data = q_wdata[q_bit_sel] ? COIL_ON : COIL_OFF;
            end
            MBPT_OP_WR_REGS: begin
              s_d.func = FC_WR_REGS;
              s_d.addr = reg_base;
              s_d.qty = ONE_REG;
              s_d.data = q_wdata;
            end
            default: begin
              s_d.func = FC_RD_REGS;
              s_d.addr = reg_base;
              s_d.qty = ONE_REG;
              s_d.data = RST_WORD;
            end
          endcase
        end
      end
      MBPT_ST_SEND: begin
        if (frm_ready) begin
          s_d.frm_valid = 1'b0;
          s_d.tries = 2'(s_q.tries + 2'h1);
          // A zero interval would never let a slave answer; treat it as one unit
          s_d.ms_left = (reply_timeout_ms == RST_WORD) ? ONE_REG : reply_timeout_ms;
          s_d.tick = '0;
          s_d.st = MBPT_ST_WAIT;
        end
      end
      MBPT_ST_WAIT: begin
        if (reply_good) begin
          s_d.done_valid = 1'b1;
          s_d.done_fail = 1'b0;
          s_d.done_data = rpl_data;
          s_d.st = MBPT_ST_IDLE;
        end else if (s_q.tick == TICK_LAST) begin
          s_d.tick = '0;
          if (s_q.ms_left <= 16'h0001) begin
            if (s_q.tries == MAX_TX) begin
              s_d.done_valid = 1'b1;
              s_d.done_fail = 1'b1;
              s_d.done_data = RST_WORD;
              s_d.st = MBPT_ST_IDLE;
            end else begin
              s_d.frm_valid = 1'b1;
              s_d.st = MBPT_ST_SEND;
            end
          end else begin
            s_d.ms_left = 16'(s_q.ms_left - 16'h0001);
          end
        end else begin
          s_d.tick = TICK_W'(s_q.tick + 1'b1);
        end
      end
      default: begin
        s_d.st = MBPT_ST_IDLE;
        s_d.frm_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.st <= MBPT_ST_IDLE;
      s_q.rx_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign frm_valid = s_q.frm_valid;
  assign frm_slave = s_q.slave;
  assign frm_func = s_q.func;
  assign frm_addr = s_q.addr;
  assign frm_qty = s_q.qty;
  assign frm_data = s_q.data;
  assign done_valid = s_q.done_valid;
  assign done_fail = s_q.done_fail;
  assign done_data = s_q.done_data;
  assign tx_drv_oe = s_q.tx_oe;
  assign rx_enable = s_q.rx_en;
  assign tx_count = s_q.tries;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_COIL_ADDR: assert property (
    (q_ready && q_valid && q_op == MBPT_OP_RD_COILS) |=>
      frm_addr == 16'({$past(q_index) + $past(addr_offset) - 16'h0001, 4'h0} + 17'h00001))
    else $error("Coil start address wrong");
  AST_REG_UNTRANSLATED: assert property (
    (q_ready && q_valid && q_op == MBPT_OP_RD_REGS) |=>
      frm_func == FC_RD_REGS && frm_addr == 16'($past(q_index) + $past(addr_offset)))
    else $error("Register request was translated");
  AST_BOUNDARY: assert property (
    (frm_valid && (frm_func == FC_RD_COILS || frm_func == FC_WR_COILS)) |->
      frm_addr[3:0] == 4'h1 && frm_qty == COILS_PER_REG)
    else $error("Coil group off boundary");
  AST_BIT_ONE: assert property (
    (frm_valid && frm_func == FC_WR_COIL) |-> frm_addr[3:0] == 4'(s_q.bit_sel + 4'h1))
    else $error("Single coil not at bit offset");
  AST_WAIT_HOLD: assert property (
    (s_q.st == MBPT_ST_WAIT && !reply_good && s_q.ms_left > 16'h0001) |=>
      s_q.st == MBPT_ST_WAIT && !frm_valid)
    else $error("Left wait before interval");
  AST_RESEND: assert property (
    (timeout_now && s_q.tries != MAX_TX) |=>
      frm_valid && $stable(frm_func) && $stable(frm_addr) && $stable(frm_data))
    else $error("Resend missing or altered");
  AST_MAX_TX: assert property (
    (timeout_now && s_q.tries == MAX_TX) |=> done_valid && done_fail && !frm_valid ##1 !done_valid)
    else $error("Fourth transmission or no failure");
  AST_TRIES_RANGE: assert property (
    (frm_valid && frm_ready) |-> tx_count != MAX_TX)
    else $error("Fourth transmission taken");
  AST_PTP: assert property (
    driver_mode == MBPT_POINT_TO_POINT_DRIVER |=> tx_drv_oe && rx_enable)
    else $error("Point-to-point driver not on");
  AST_CTS_FOLLOW: assert property (
    (driver_mode == MBPT_DRIVER_MODE_A && $stable(cts))[*3] |=> tx_drv_oe == $past(cts, 3))
    else $error("Driver not following CTS");
  AST_HALF_DUPLEX: assert property (
    (driver_mode == MBPT_DRIVER_MODE_B && (tx_busy || frm_valid)) |=> !rx_enable)
    else $error("Receiver on while transmitting");
  AST_STOP_ON_REPLY: assert property (
    (s_q.st == MBPT_ST_WAIT && reply_good) |=>
      done_valid && !done_fail && done_data == $past(rpl_data) && !frm_valid)
    else $error("Valid reply did not end request");

  COV_FIRST_TRY: cover property (
    s_q.st == MBPT_ST_WAIT && reply_good && s_q.tries == 2'h1);
  COV_FAIL: cover property (timeout_now && s_q.tries == MAX_TX);
  COV_COIL_WRITE: cover property (frm_valid && frm_ready && frm_func == FC_WR_COILS);
  COV_QUEUE_FULL: cover property (!req_ready);
endmodule

`default_nettype wire

// file: tb/mbpt_slave_model.sv
// Behavioural serializer, deserializer and slave behind the port
`timescale 1ns/1ps
`default_nettype none
module mbpt_slave_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Frame link
  input wire logic frm_valid,
  output logic frm_ready,
  input wire logic [15:0] frm_addr,
  // Reply link
  output logic rpl_valid,
  output logic rpl_ok,
  output logic [15:0] rpl_data,
  output logic tx_busy,
  // Test control and log
  input wire logic stall,
  input wire logic [1:0] drops,
  output logic [7:0] frames,
  output logic [15:0] gap
);
  logic [1:0] busy_cnt = 2'h0;
  logic [1:0] miss = 2'h0;
  logic [15:0] cyc = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic [15:0] addr_q = 16'h0000;
  // Line framing (9600 baud, 8 data, even parity, 1 stop) sits outside this model
  // Full or half duplex follows the driver mode the bench selects
  assign tx_busy = (busy_cnt != 2'h0);
  always @(posedge clk) begin
    cyc <= cyc + 16'h0001;
    frm_ready <= 1'b0;
    rpl_valid <= 1'b0;
    rpl_ok <= ~rpl_ok;
    // Idle reply data keeps moving so a stale value never looks valid
    rpl_data <= ~rpl_data;
    if (srst) begin
      busy_cnt <= 2'h0;
      miss <= 2'h0;
      frames <= 8'h00;
      gap <= 16'h0000;
      rpl_ok <= 1'b0;
      rpl_data <= 16'h0000;
    end else if (frm_valid && frm_ready) begin
      frames <= frames + 8'h01;
      gap <= cyc - last;
      last <= cyc;
      addr_q <= frm_addr;
      busy_cnt <= 2'h3;
    end else if (busy_cnt != 2'h0) begin
      busy_cnt <= busy_cnt - 2'h1;
      if (busy_cnt == 2'h1 && miss < drops) begin
        // Garbled reply: pulse without ok, must not end the wait
        miss <= miss + 2'h1;
        rpl_valid <= 1'b1;
        rpl_ok <= 1'b0;
      end else if (busy_cnt == 2'h1) begin
        miss <= 2'h0;
        rpl_valid <= 1'b1;
        rpl_ok <= 1'b1;
        rpl_data <= addr_q;
      end
    end else if (frm_valid && !stall) begin
      frm_ready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the serial master port translator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mbpt_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  mbpt_op_e req_op = MBPT_OP_RD_REGS;
  logic [7:0] req_slave = 8'h00;
  logic [15:0] req_index = 16'h0000;
  logic [3:0] req_bit_sel = 4'h0;
  logic [15:0] req_data = 16'h0000;
  logic [15:0] addr_offset = 16'h0000;
  logic [15:0] reply_timeout_ms = 16'h0002;
  mbpt_drv_e driver_mode = MBPT_POINT_TO_POINT_DRIVER;
  logic cts = 1'b0;
  logic stall = 1'b0;
  logic [1:0] drops = 2'h0;
  logic req_ready, done_valid, done_fail, frm_valid, frm_ready, rpl_valid, rpl_ok;
  logic tx_busy, tx_drv_oe, rx_enable, d_fail, busy_q;
  logic ptp_watch = 1'b0;
  logic [15:0] done_data, frm_addr, frm_qty, frm_data, rpl_data, gap, d_data, idx, off, st, ea;
  logic [7:0] frm_slave, frm_func, frames, f0;
  logic [1:0] tx_count, d_cnt;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int rx_bad = 0;
  int busy_seen = 0;
  int ptp_bad = 0;

  mbpt_port #(.TICK(4)) u_mbpt_port (.clk(clk), .srst(srst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_slave(req_slave), .req_index(req_index),
    .req_bit_sel(req_bit_sel), .req_data(req_data), .done_valid(done_valid),
    .done_fail(done_fail), .done_data(done_data), .addr_offset(addr_offset),
    .reply_timeout_ms(reply_timeout_ms), .driver_mode(driver_mode), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_slave(frm_slave), .frm_func(frm_func), .frm_addr(frm_addr),
    .frm_qty(frm_qty), .frm_data(frm_data), .rpl_valid(rpl_valid), .rpl_ok(rpl_ok),
    .rpl_data(rpl_data), .tx_busy(tx_busy), .cts(cts), .tx_drv_oe(tx_drv_oe),
    .rx_enable(rx_enable), .tx_count(tx_count));
  mbpt_slave_model u_mbpt_slave_model (.clk(clk), .srst(srst), .frm_valid(frm_valid),
    .frm_ready(frm_ready), .frm_addr(frm_addr), .rpl_valid(rpl_valid), .rpl_ok(rpl_ok),
    .rpl_data(rpl_data), .tx_busy(tx_busy), .stall(stall), .drops(drops), .frames(frames),
    .gap(gap));

  always #4 clk = ~clk;

  task automatic give_verdict();
    if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic push(input mbpt_op_e op, input logic [15:0] ix, input logic [15:0] dat);
    @(negedge clk);
    req_op = op;
    req_index = ix;
    req_data = dat;
    req_slave = 8'h5a;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    @(negedge clk);
    while (done_valid !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) chk(64'h0, 64'h1);
    d_fail = done_fail;
    d_data = done_data;
    d_cnt = tx_count;
  endtask

  // Sampled just after the falling edge so bench updates have landed
  always @(negedge clk) begin
    #2;
    if (driver_mode == MBPT_DRIVER_MODE_B && busy_q && tx_busy && rx_enable !== 1'b0) rx_bad++;
    if (ptp_watch && (rx_enable !== 1'b1 || tx_drv_oe !== 1'b1)) ptp_bad++;
    if (tx_busy) busy_seen++;
    busy_q = tx_busy;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({frm_valid, done_valid, tx_count, tx_drv_oe, rx_enable, req_ready},
        {1'b0, 1'b0, 2'h0, 1'b0, 1'b1, 1'b1});
    srst = 1'b0;
    repeat (4) @(negedge clk);
    ptp_watch = 1'b1;
    for (int p = 0; p < 2; p++) begin
      off = p ? 16'd500 : 16'd0;
      idx = p ? 16'd7 : 16'd1;
      addr_offset = off;
      // Bit zero and bit fifteen bracket the single-coil offsets
      req_bit_sel = p ? 4'hf : 4'h0;
      st = ((idx + off - 16'h1) * 16'h10) + 16'h1;
      for (int k = 0; k < 5; k++) begin
        f0 = frames;
        push(mbpt_op_e'(k), idx, p ? 16'hffff : 16'h0000);
        wait_done();
        chk({d_fail, d_cnt, frames - f0}, {1'b0, 2'h1, 8'h01});
        chk(frm_slave, 8'h5a);
        case (k)
          0: chk({frm_func, frm_addr, frm_qty}, {FC_RD_REGS, idx + off, ONE_REG});
          1: chk({frm_func, frm_addr, frm_data}, {FC_WR_REGS, idx + off, req_data});
          2: chk({frm_func, frm_addr, frm_qty},
                 {FC_RD_COILS, st, COILS_PER_REG});
          3: chk({frm_func, frm_addr, frm_qty, frm_data},
                 {FC_WR_COILS, st, COILS_PER_REG, req_data});
          default: chk({frm_func, frm_addr, frm_data},
                       {FC_WR_COIL, 16'(st + req_bit_sel), p ? COIL_ON : COIL_OFF});
        endcase
        ea = (k < 2) ? idx + off : (k == 4) ? 16'(st + req_bit_sel) : st;
        chk(d_data, ea);
      end
    end
    chk(ptp_bad, 0);
    ptp_watch = 1'b0;
    drops = 2'h2;
    f0 = frames;
    push(MBPT_OP_RD_REGS, 16'h0003, 16'h0000);
    wait_done();
    chk({d_fail, d_cnt, frames - f0, d_data}, {1'b0, 2'h3, 8'h03, 16'h01f7});
    chk(gap >= 16'd8 && gap <= 16'd14, 1);
    drops = 2'h3;
    f0 = frames;
    push(MBPT_OP_RD_REGS, 16'h0004, 16'h0000);
    wait_done();
    chk({d_fail, frames - f0, d_data}, {1'b1, 8'h03, 16'h0000});
    drops = 2'h0;
    // Stalled serializer: one request parks in the port, sixteen fill the queue
    stall = 1'b1;
    addr_offset = 16'h0000;
    for (int i = 1; i <= 17; i++) push(MBPT_OP_RD_REGS, 16'(i), 16'h0000);
    chk({req_ready, frm_valid, tx_count}, {1'b0, 1'b1, 2'h0});
    stall = 1'b0;
    for (int i = 1; i <= 17; i++) begin
      wait_done();
      chk({d_fail, d_data}, {1'b0, 16'(i)});
    end
    driver_mode = MBPT_DRIVER_MODE_A;
    repeat (5) @(negedge clk);
    chk(tx_drv_oe, 1'b0);
    cts = 1'b1;
    repeat (5) @(negedge clk);
    chk(tx_drv_oe, 1'b1);
    driver_mode = MBPT_DRIVER_MODE_B;
    busy_seen = 0;
    push(MBPT_OP_WR_REGS, 16'h0009, 16'h1234);
    wait_done();
    chk({busy_seen > 0, rx_bad}, {1'b1, 32'h0});
    cts = 1'b0;
    repeat (5) @(negedge clk);
    chk(tx_drv_oe, 1'b0);
    // Unused mode code keeps the line undriven even with CTS up
    cts = 1'b1;
    driver_mode = mbpt_drv_e'(2'b11);
    repeat (5) @(negedge clk);
    chk({tx_drv_oe, rx_enable}, 2'b01);
    give_verdict();
  end
endmodule
`default_nettype wire
